// file: verilog/sstl_top.sv
// status registers and triggered voltage store behind the command port
//
// Behaviour
// [R1] pending voltage reaches output only on trigger
// [R2] above model maximum posts error -222
// [R3] above upper ceiling stores the ceiling
// [R4] voltage query returns stored pending value
// [R5] operation condition: bit10 current, bit8 voltage
// [R6] status bit 7 ORs enabled operation events
// [R7] operation mask writable, reads back masked to bits 0,5,8,10
// [R8] operation events latch, read returns then clears
// [R9] preset forces both condition registers to zero
// [R10] only questionable bits 13 and 12 latch
// [R11] questionable event read returns then clears
// [R12] questionable condition: 13,12 errors, 1,0 modes
// [R13] questionable bits 1 and 0 may coexist
// [R14] status bit 3 ORs enabled questionable events
// [R15] operation values limited to bits 0,5,8,10
// [R16] questionable mask query returns stored mask
// [R17] event sets on condition rise, holds till read
// [R18] sixteen-bit registers, unused bits read zero
`timescale 1ns/100ps
module sstl_top (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// command port from the parser
	input wire logic cmd_valid_i,
	input wire logic [3:0] cmd_code_i,
	input wire logic [15:0] cmd_data_i,
	// query answers
	output logic rsp_valid_o,
	output logic [15:0] rsp_data_o,
	// error queue feed
	output logic err_valid_o,
	output logic [15:0] err_code_o,
	// live power stage state, asynchronous
	input wire logic in_current_regulation_i,
	input wire logic in_voltage_regulation_i,
	input wire logic current_fault_flag_i,
	input wire logic voltage_fault_flag_i,
	input wire logic current_regulation_flag_i,
	input wire logic voltage_regulation_flag_i,
	// status byte summary bits
	output logic stb_oper_summary_o,
	output logic stb_ques_summary_o,
	// output setpoint
	output logic [15:0] vout_setpoint_o,
	output logic vout_load_o,
	output logic [15:0] upper_voltage_ceiling_o
);

	typedef struct packed {
		// one-cycle answer and error pulses
		logic rsp_valid;
		logic [15:0] rsp_data;
		logic err_valid;
		logic [15:0] err_code;
		// pending value and ceiling
		logic [15:0] pend_v;
		logic [15:0] ceil_v;
		// applied setpoint
		logic [15:0] vout;
		logic vout_load;
	} sstl_top_st_t;

	sstl_top_st_t r;
	sstl_top_st_t n;

	// synchroniser in and out
	logic [5:0] live_async;
	logic [5:0] live;

	// levels placed on condition bit positions
	logic [15:0] oper_live;
	logic [15:0] ques_live;

	// registered views of the two groups
	logic [15:0] oper_cond;
	logic [15:0] oper_ev;
	logic [15:0] oper_enab;
	logic [15:0] ques_cond;
	logic [15:0] ques_ev;
	logic [15:0] ques_enab;
	logic oper_summ;
	logic ques_summ;

	// decoded strobes into the groups
	logic preset;
	logic oper_enab_wr;
	logic ques_enab_wr;
	logic oper_ev_rd;
	logic ques_ev_rd;

	// command code seen as its enum
	sstl_pkg::sstl_cmd_t cmd;

	// power stage levels come from outside this clock and are synchronised
	always_comb begin
		live_async = sstl_pkg::LIVE_RST;
		live_async[sstl_pkg::LIVE_CURR] = in_current_regulation_i;
		live_async[sstl_pkg::LIVE_VOLT] = in_voltage_regulation_i;
		live_async[sstl_pkg::LIVE_CFAULT] = current_fault_flag_i;
		live_async[sstl_pkg::LIVE_VFAULT] = voltage_fault_flag_i;
		live_async[sstl_pkg::LIVE_CREG] = current_regulation_flag_i;
		live_async[sstl_pkg::LIVE_VREG] = voltage_regulation_flag_i;
	end

	sstl_sync #(
		.W(sstl_pkg::LIVE_W)
	) sstl_sync_inst (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.async_i(live_async),
		.settled_o(live)
	);

	// map live levels onto condition bit positions; other bits stay zero
	always_comb begin
		oper_live = sstl_pkg::STAT_RST;
		ques_live = sstl_pkg::STAT_RST;
		// operation group: regulation modes only
		oper_live[sstl_pkg::OPER_CURR_BIT] = live[sstl_pkg::LIVE_CURR]; // R5
		oper_live[sstl_pkg::OPER_VOLT_BIT] = live[sstl_pkg::LIVE_VOLT]; // R5
		// questionable group: fault flags
		ques_live[sstl_pkg::QUES_CFAULT_BIT] = live[sstl_pkg::LIVE_CFAULT]; // R12
		ques_live[sstl_pkg::QUES_VFAULT_BIT] = live[sstl_pkg::LIVE_VFAULT]; // R12
		// both mode bits pass untouched: together they mean settling
		ques_live[sstl_pkg::QUES_CREG_BIT] = live[sstl_pkg::LIVE_CREG]; // R13
		ques_live[sstl_pkg::QUES_VREG_BIT] = live[sstl_pkg::LIVE_VREG]; // R13
	end

	// command decode into group strobes
	always_comb begin
		cmd = sstl_pkg::sstl_cmd_t'(cmd_code_i);
		preset = cmd_valid_i && (cmd == sstl_pkg::CMD_STAT_PRESET); // R9
		// mask writes
		oper_enab_wr = cmd_valid_i && (cmd == sstl_pkg::CMD_OPER_ENAB_SET); // R7
		ques_enab_wr = cmd_valid_i && (cmd == sstl_pkg::CMD_QUES_ENAB_SET); // R16
		// event reads clear their register after answering
		oper_ev_rd = cmd_valid_i && (cmd == sstl_pkg::CMD_OPER_EVEN_QRY); // R8
		ques_ev_rd = cmd_valid_i && (cmd == sstl_pkg::CMD_QUES_EVEN_QRY); // R11
	end

	// operation group; masks keep every value within bits 0, 5, 8 and 10
	sstl_group #(
		.LIVE_MASK(sstl_pkg::OPER_LIVE_MASK),
		.LATCH_MASK(sstl_pkg::OPER_LATCH_MASK),
		.ENAB_MASK(sstl_pkg::OPER_ENAB_MASK)
	) sstl_group_oper_inst (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.live_i(oper_live),
		.preset_i(preset),
		.enab_wr_i(oper_enab_wr),
		.enab_data_i(cmd_data_i),
		.ev_rd_i(oper_ev_rd),
		.cond_o(oper_cond),
		.ev_o(oper_ev),
		.enab_o(oper_enab),
		.summary_o(oper_summ)
	); // R15 R17 R18

	// questionable group; mode bits are live only and never latch
	sstl_group #(
		.LIVE_MASK(sstl_pkg::QUES_LIVE_MASK),
		.LATCH_MASK(sstl_pkg::QUES_LATCH_MASK),
		.ENAB_MASK(sstl_pkg::QUES_ENAB_MASK)
	) sstl_group_ques_inst (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.live_i(ques_live),
		.preset_i(preset),
		.enab_wr_i(ques_enab_wr),
		.enab_data_i(cmd_data_i),
		.ev_rd_i(ques_ev_rd),
		.cond_o(ques_cond),
		.ev_o(ques_ev),
		.enab_o(ques_enab),
		.summary_o(ques_summ)
	); // R10 R17 R18

	// summary bits are group flops, passed out unchanged
	assign stb_oper_summary_o = oper_summ; // R6
	assign stb_ques_summary_o = ques_summ; // R14

	// command execution; answers and error pulses last exactly one cycle
	always_comb begin
		n = r;
		// pulses drop unless this command raises them
		n.rsp_valid = 1'b0;
		n.rsp_data = sstl_pkg::STAT_RST;
		n.err_valid = 1'b0;
		n.err_code = sstl_pkg::ERR_NONE;
		n.vout_load = 1'b0;
		// idle cycles leave every stored value alone
		if (cmd_valid_i) begin
			case (cmd)
				sstl_pkg::CMD_VTRIG_SET: begin
					// an out-of-range value is refused and the pending value kept
					if (cmd_data_i > sstl_pkg::VOLT_MODEL_MAX) begin
						n.err_valid = 1'b1; // R2
						n.err_code = sstl_pkg::ERR_DATA_RANGE; // R2
					end else if (cmd_data_i > r.ceil_v) begin
						n.pend_v = r.ceil_v; // R3
					end else begin
						n.pend_v = cmd_data_i; // R1
					end
				end
				sstl_pkg::CMD_VTRIG_QRY: begin
					n.rsp_valid = 1'b1;
					n.rsp_data = r.pend_v; // R4
				end
				sstl_pkg::CMD_TRIGGER: begin
					n.vout = r.pend_v; // R1
					n.vout_load = 1'b1; // R1
				end
				sstl_pkg::CMD_VLIM_SET: begin
					// a ceiling beyond the model cannot be honoured
					if (cmd_data_i > sstl_pkg::VOLT_MODEL_MAX) begin
						n.err_valid = 1'b1;
						n.err_code = sstl_pkg::ERR_DATA_RANGE;
					end else begin
						n.ceil_v = cmd_data_i;
					end
				end
				sstl_pkg::CMD_OPER_COND_QRY: begin
					n.rsp_valid = 1'b1;
					n.rsp_data = oper_cond; // R5
				end
				sstl_pkg::CMD_OPER_ENAB_QRY: begin
					n.rsp_valid = 1'b1;
					n.rsp_data = oper_enab; // R7
				end
				sstl_pkg::CMD_OPER_EVEN_QRY: begin
					n.rsp_valid = 1'b1;
					n.rsp_data = oper_ev; // R8
				end
				sstl_pkg::CMD_QUES_EVEN_QRY: begin
					n.rsp_valid = 1'b1;
					n.rsp_data = ques_ev; // R11
				end
				sstl_pkg::CMD_QUES_COND_QRY: begin
					n.rsp_valid = 1'b1;
					n.rsp_data = ques_cond; // R12
				end
				sstl_pkg::CMD_QUES_ENAB_QRY: begin
					n.rsp_valid = 1'b1;
					n.rsp_data = ques_enab; // R16
				end
				sstl_pkg::CMD_OPER_ENAB_SET: begin
					// mask lands in the operation group, no answer
					n.rsp_valid = 1'b0; // R7
				end
				sstl_pkg::CMD_QUES_ENAB_SET: begin
					// mask lands in the questionable group, no answer
					n.rsp_valid = 1'b0; // R16
				end
				sstl_pkg::CMD_STAT_PRESET: begin
					// groups zero their conditions; events stay untouched
					n.rsp_valid = 1'b0; // R9
				end
				sstl_pkg::CMD_NOP: begin
					// filler code from the parser, ignored
					n.rsp_valid = 1'b0;
				end
				default: begin
					// codes beyond the table are ignored
					n.rsp_valid = 1'b0;
				end
			endcase
		end
	end

	// ceiling starts at the model maximum so nothing clamps before it is set
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			r.rsp_valid <= 1'b0;
			r.rsp_data <= sstl_pkg::STAT_RST;
			r.err_valid <= 1'b0;
			r.err_code <= sstl_pkg::ERR_NONE;
			r.pend_v <= sstl_pkg::VOLT_RST;
			r.ceil_v <= sstl_pkg::VOLT_MODEL_MAX;
			r.vout <= sstl_pkg::VOLT_RST;
			r.vout_load <= 1'b0;
		end else begin
			r <= n;
		end
	end

	// query answer
	assign rsp_valid_o = r.rsp_valid;
	assign rsp_data_o = r.rsp_data;

	// error post
	assign err_valid_o = r.err_valid;
	assign err_code_o = r.err_code;

	// applied setpoint and ceiling
	assign vout_setpoint_o = r.vout;
	assign vout_load_o = r.vout_load;
	assign upper_voltage_ceiling_o = r.ceil_v;

endmodule

// file: include/sstl_pkg.sv
// constants, command codes and bit layout of the status and trigger-level block
package sstl_pkg;

	// register and data widths
	localparam int STAT_W = 16;
	localparam int VOLT_W = 16;
	localparam int LIVE_W = 6;
	localparam int CMD_W = 4;

	// operation group bit positions
	localparam int OPER_CURR_BIT = 10;
	localparam int OPER_VOLT_BIT = 8;
	// questionable group bit positions
	localparam int QUES_CFAULT_BIT = 13;
	localparam int QUES_VFAULT_BIT = 12;
	localparam int QUES_CREG_BIT = 1;
	localparam int QUES_VREG_BIT = 0;

	// live input vector positions after synchronising
	localparam int LIVE_CURR = 0;
	localparam int LIVE_VOLT = 1;
	localparam int LIVE_CFAULT = 2;
	localparam int LIVE_VFAULT = 3;
	localparam int LIVE_CREG = 4;
	localparam int LIVE_VREG = 5;

	// bit sets of each group
	localparam logic [15:0] OPER_LIVE_MASK = 16'h0500;
	localparam logic [15:0] OPER_LATCH_MASK = 16'h0500;
	localparam logic [15:0] OPER_ENAB_MASK = 16'h0521;
	localparam logic [15:0] QUES_LIVE_MASK = 16'h3003;
	localparam logic [15:0] QUES_LATCH_MASK = 16'h3000;
	localparam logic [15:0] QUES_ENAB_MASK = 16'h3003;

	// reset values
	localparam logic [15:0] STAT_RST = 16'h0000;
	localparam logic [15:0] VOLT_RST = 16'h0000;
	localparam logic [5:0] LIVE_RST = 6'h00;

	// model maximum voltage code, also the reset ceiling
	localparam logic [15:0] VOLT_MODEL_MAX = 16'hFFF0;

	// error -222, data out of range, in two's complement
	localparam logic [15:0] ERR_DATA_RANGE = 16'hFF22;
	localparam logic [15:0] ERR_NONE = 16'h0000;

	// command codes on the command port
	typedef enum logic [3:0] {
		CMD_NOP = 4'h0,
		CMD_VTRIG_SET = 4'h1,
		CMD_VTRIG_QRY = 4'h2,
		CMD_TRIGGER = 4'h3,
		CMD_OPER_COND_QRY = 4'h4,
		CMD_OPER_ENAB_SET = 4'h5,
		CMD_OPER_ENAB_QRY = 4'h6,
		CMD_OPER_EVEN_QRY = 4'h7,
		CMD_STAT_PRESET = 4'h8,
		CMD_QUES_EVEN_QRY = 4'h9,
		CMD_QUES_COND_QRY = 4'hA,
		CMD_QUES_ENAB_SET = 4'hB,
		CMD_QUES_ENAB_QRY = 4'hC,
		CMD_VLIM_SET = 4'hD
	} sstl_cmd_t;

endpackage

// file: verilog/sstl_sync.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module sstl_sync #(
	parameter int W = 6
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// asynchronous levels in, settled levels out
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] settled_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] held;
	} sstl_sync_st_t;

	sstl_sync_st_t r;
	sstl_sync_st_t n;

	// s1 feeds s2 only; per-bit agreement of s2 and s3 updates the held level
	always_comb begin
		n = r;
		n.s1 = async_i;
		n.s2 = r.s1;
		n.s3 = r.s2;
		for (int i = 0; i < W; i++) begin
			if (r.s2[i] == r.s3[i]) begin
				n.held[i] = r.s3[i];
			end
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign settled_o = r.held;

endmodule

// file: verilog/sstl_group.sv
// one status group: live condition, read-clear event latch, enable mask, summary
`timescale 1ns/100ps
module sstl_group #(
	parameter logic [15:0] LIVE_MASK = 16'hFFFF,
	parameter logic [15:0] LATCH_MASK = 16'hFFFF,
	parameter logic [15:0] ENAB_MASK = 16'hFFFF
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// live state and control strobes
	input wire logic [15:0] live_i,
	input wire logic preset_i,
	input wire logic enab_wr_i,
	input wire logic [15:0] enab_data_i,
	input wire logic ev_rd_i,
	// registered views
	output logic [15:0] cond_o,
	output logic [15:0] ev_o,
	output logic [15:0] enab_o,
	output logic summary_o
);

	typedef struct packed {
		logic [15:0] prev;
		logic [15:0] cond;
		logic [15:0] ev;
		logic [15:0] enab;
		logic summ;
	} sstl_grp_st_t;

	sstl_grp_st_t r;
	sstl_grp_st_t n;
	logic [15:0] rise;

	// events are rising edges of latching bits; a new edge beats the read clear
	always_comb begin
		n = r;
		n.prev = live_i & LIVE_MASK;
		rise = n.prev & ~r.prev & LATCH_MASK;
		n.cond = preset_i ? sstl_pkg::STAT_RST : n.prev;
		n.ev = ((ev_rd_i ? sstl_pkg::STAT_RST : r.ev) | rise) & LATCH_MASK;
		if (enab_wr_i) begin
			n.enab = enab_data_i & ENAB_MASK;
		end
		// summary follows the next values so it matches the registers exactly
		n.summ = |(n.ev & n.enab);
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign cond_o = r.cond;
	assign ev_o = r.ev;
	assign enab_o = r.enab;
	assign summary_o = r.summ;

endmodule

// file: test/sstl_checker.sv
// concurrent checks on the command port and status outputs
`timescale 1ns/100ps
module sstl_checker (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// command port and answers
	input wire logic cmd_valid_i,
	input wire logic [3:0] cmd_code_i,
	input wire logic [15:0] cmd_data_i,
	input wire logic rsp_valid_o,
	input wire logic [15:0] rsp_data_o,
	input wire logic err_valid_o,
	input wire logic [15:0] err_code_o,
	// summaries and setpoint
	input wire logic stb_oper_summary_o,
	input wire logic stb_ques_summary_o,
	input wire logic [15:0] vout_setpoint_o,
	input wire logic vout_load_o
);
	// one clock domain, so one default clocking and reset
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	trig_load_a: assert property (
		cmd_valid_i && cmd_code_i == sstl_pkg::CMD_TRIGGER |=> vout_load_o)
		else $error("trigger gave no load pulse");
	load_cause_a: assert property (
		vout_load_o |-> $past(cmd_valid_i && cmd_code_i == sstl_pkg::CMD_TRIGGER))
		else $error("load pulse without trigger");
	setpoint_hold_a: assert property (
		!vout_load_o |-> $stable(vout_setpoint_o))
		else $error("setpoint moved without load");
	range_err_a: assert property (
		cmd_valid_i && cmd_code_i == sstl_pkg::CMD_VTRIG_SET
		&& cmd_data_i > sstl_pkg::VOLT_MODEL_MAX
		|=> err_valid_o && err_code_o == sstl_pkg::ERR_DATA_RANGE)
		else $error("no range error posted");
	err_cause_a: assert property (
		err_valid_o |-> $past(cmd_valid_i && cmd_data_i > sstl_pkg::VOLT_MODEL_MAX))
		else $error("error posted for legal value");
	oper_enab_a: assert property (
		cmd_valid_i && cmd_code_i == sstl_pkg::CMD_OPER_ENAB_QRY
		|=> rsp_valid_o && (rsp_data_o & ~sstl_pkg::OPER_ENAB_MASK) == 16'h0000)
		else $error("operation mask has stray bits");
	oper_cond_a: assert property (
		cmd_valid_i && cmd_code_i == sstl_pkg::CMD_OPER_COND_QRY
		|=> rsp_valid_o && (rsp_data_o & 16'hFAFF) == 16'h0000)
		else $error("operation condition has stray bits");
	ques_event_a: assert property (
		cmd_valid_i && cmd_code_i == sstl_pkg::CMD_QUES_EVEN_QRY
		|=> rsp_valid_o && (rsp_data_o & 16'hCFFF) == 16'h0000)
		else $error("questionable event latched a mode bit");
	oper_sum_a: assert property (
		cmd_valid_i && cmd_code_i == sstl_pkg::CMD_OPER_ENAB_SET
		&& cmd_data_i == 16'h0000 |=> !stb_oper_summary_o)
		else $error("operation summary with empty mask");
	ques_sum_a: assert property (
		cmd_valid_i && cmd_code_i == sstl_pkg::CMD_QUES_ENAB_SET
		&& cmd_data_i == 16'h0000 |=> !stb_ques_summary_o)
		else $error("questionable summary with empty mask");
endmodule

bind sstl_top sstl_checker sstl_checker_inst (.mclk_i, .rst_i, .cmd_valid_i, .cmd_code_i,
	.cmd_data_i, .rsp_valid_o, .rsp_data_o, .err_valid_o, .err_code_o, .stb_oper_summary_o,
	.stb_ques_summary_o, .vout_setpoint_o, .vout_load_o);

// file: test/sstl_host.sv
// host model issuing one-cycle commands and collecting answers
`timescale 1ns/100ps
module sstl_host (
	// clock
	input wire logic mclk_i,
	// command port
	output logic cmd_valid_o,
	output logic [3:0] cmd_code_o,
	output logic [15:0] cmd_data_o,
	// answers
	input wire logic rsp_valid_i,
	input wire logic [15:0] rsp_data_i
);
	int rsp_cnt = 0;
	logic [15:0] rsp_last = 16'h0000;

	// idle port at time zero
	initial begin
		cmd_valid_o = 1'b0;
		cmd_code_o = 4'h0;
		cmd_data_o = 16'h0000;
	end

	// answer stands one cycle, so take it on the sampling edge
	always @(posedge mclk_i) begin
		if (rsp_valid_i) begin
			rsp_last <= rsp_data_i;
			rsp_cnt <= rsp_cnt + 1;
		end
	end

	// drives one command; calls in a row give back-to-back commands
	task automatic send(input logic [3:0] code, input logic [15:0] data);
		@(negedge mclk_i);
		cmd_valid_o = 1'b1;
		cmd_code_o = code;
		cmd_data_o = data;
	endtask

	// release shows inverted lines so stale data is never mistaken
	task automatic idle();
		@(negedge mclk_i);
		cmd_valid_o = 1'b0;
		cmd_code_o = ~cmd_code_o;
		cmd_data_o = ~cmd_data_o;
	endtask
endmodule

// file: test/sstl_top_tb.sv
// self-checking bench for the status and trigger-level block
`timescale 1ns/100ps
module sstl_top_tb;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cmd_valid_i, rsp_valid_o, err_valid_o, vout_load_o;
	logic stb_oper_summary_o, stb_ques_summary_o;
	logic [3:0] cmd_code_i;
	logic [15:0] cmd_data_i, rsp_data_o, err_code_o, vout_setpoint_o, upper_voltage_ceiling_o;
	logic [5:0] live = 6'h00;
	int error_cnt = 0;
	int tests_run = 0;

	// 250 MHz clock
	initial forever #2 mclk_i = ~mclk_i;

	sstl_host sstl_host_inst (.mclk_i(mclk_i), .cmd_valid_o(cmd_valid_i),
		.cmd_code_o(cmd_code_i), .cmd_data_o(cmd_data_i), .rsp_valid_i(rsp_valid_o),
		.rsp_data_i(rsp_data_o));

	sstl_top sstl_top_inst (.mclk_i(mclk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
		.cmd_code_i(cmd_code_i), .cmd_data_i(cmd_data_i), .rsp_valid_o(rsp_valid_o),
		.rsp_data_o(rsp_data_o), .err_valid_o(err_valid_o), .err_code_o(err_code_o),
		.in_current_regulation_i(live[0]), .in_voltage_regulation_i(live[1]),
		.current_fault_flag_i(live[2]), .voltage_fault_flag_i(live[3]),
		.current_regulation_flag_i(live[4]), .voltage_regulation_flag_i(live[5]),
		.stb_oper_summary_o(stb_oper_summary_o), .stb_ques_summary_o(stb_ques_summary_o),
		.vout_setpoint_o(vout_setpoint_o), .vout_load_o(vout_load_o),
		.upper_voltage_ceiling_o(upper_voltage_ceiling_o));

	task automatic close_out();
		$display("mismatches %0d of %0d checks", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic set(input logic [3:0] code, input logic [15:0] data);
		sstl_host_inst.send(code, data);
		sstl_host_inst.idle();
	endtask

	// query, then wait a bounded time for the one-cycle answer
	task automatic ask(input logic [3:0] code, input logic [15:0] exp);
		int n;
		int i;
		n = sstl_host_inst.rsp_cnt;
		set(code, 16'h0000);
		for (i = 0; i < 8 && sstl_host_inst.rsp_cnt == n; i++) @(negedge mclk_i);
		if (sstl_host_inst.rsp_cnt == n) begin
			error_cnt++;
			$display("MISMATCH at %0t: no answer", $time);
			close_out();
		end else chk(sstl_host_inst.rsp_last, exp);
	endtask

	// live levels pass a synchroniser; eight cycles covers its delay
	task automatic settle();
		repeat (8) @(negedge mclk_i);
	endtask

	// pending value held until trigger, clamped, refused above maximum
	task automatic t_trig();
		set(sstl_pkg::CMD_VTRIG_SET, 16'h1234);
		ask(sstl_pkg::CMD_VTRIG_QRY, 16'h1234);
		chk(vout_setpoint_o, 16'h0000);
		set(sstl_pkg::CMD_TRIGGER, 16'h0000);
		chk({15'h0000, vout_load_o}, 16'h0001);
		chk(vout_setpoint_o, 16'h1234);
		set(sstl_pkg::CMD_VLIM_SET, 16'h0800);
		chk(upper_voltage_ceiling_o, 16'h0800);
		set(sstl_pkg::CMD_VTRIG_SET, 16'h1000);
		ask(sstl_pkg::CMD_VTRIG_QRY, 16'h0800);
		set(sstl_pkg::CMD_VTRIG_SET, 16'hFFF1);
		chk({15'h0000, err_valid_o}, 16'h0001);
		chk(err_code_o, sstl_pkg::ERR_DATA_RANGE);
		ask(sstl_pkg::CMD_VTRIG_QRY, 16'h0800);
		set(sstl_pkg::CMD_VLIM_SET, 16'hFFF1);
		chk(err_code_o, sstl_pkg::ERR_DATA_RANGE);
		chk(upper_voltage_ceiling_o, 16'h0800);
	endtask

	// operation group: mask, live state, latch, read-clear, summary
	task automatic t_oper();
		set(sstl_pkg::CMD_OPER_ENAB_SET, 16'hFFFF);
		ask(sstl_pkg::CMD_OPER_ENAB_QRY, 16'h0521);
		set(sstl_pkg::CMD_OPER_ENAB_SET, 16'h0500);
		ask(sstl_pkg::CMD_OPER_ENAB_QRY, 16'h0500);
		live[1] = 1'b1;
		settle();
		ask(sstl_pkg::CMD_OPER_COND_QRY, 16'h0100);
		chk({15'h0000, stb_oper_summary_o}, 16'h0001);
		ask(sstl_pkg::CMD_OPER_EVEN_QRY, 16'h0100);
		ask(sstl_pkg::CMD_OPER_EVEN_QRY, 16'h0000);
		set(sstl_pkg::CMD_OPER_ENAB_SET, 16'h0000);
		live[0] = 1'b1;
		settle();
		ask(sstl_pkg::CMD_OPER_COND_QRY, 16'h0500);
		chk({15'h0000, stb_oper_summary_o}, 16'h0000);
		set(sstl_pkg::CMD_OPER_ENAB_SET, 16'h0400);
		settle();
		chk({15'h0000, stb_oper_summary_o}, 16'h0001);
		ask(sstl_pkg::CMD_OPER_EVEN_QRY, 16'h0400);
	endtask

	// questionable group: mode bits never latch, fault bits do
	task automatic t_ques();
		set(sstl_pkg::CMD_QUES_ENAB_SET, 16'hFFFF);
		ask(sstl_pkg::CMD_QUES_ENAB_QRY, 16'h3003);
		live[4] = 1'b1;
		live[5] = 1'b1;
		settle();
		ask(sstl_pkg::CMD_QUES_COND_QRY, 16'h0003);
		ask(sstl_pkg::CMD_QUES_EVEN_QRY, 16'h0000);
		live[3] = 1'b1;
		settle();
		ask(sstl_pkg::CMD_QUES_COND_QRY, 16'h1003);
		chk({15'h0000, stb_ques_summary_o}, 16'h0001);
		ask(sstl_pkg::CMD_QUES_EVEN_QRY, 16'h1000);
		ask(sstl_pkg::CMD_QUES_EVEN_QRY, 16'h0000);
		live[2] = 1'b1;
		settle();
		ask(sstl_pkg::CMD_QUES_COND_QRY, 16'h3003);
		ask(sstl_pkg::CMD_QUES_EVEN_QRY, 16'h2000);
		set(sstl_pkg::CMD_QUES_ENAB_SET, 16'h0000);
	endtask

	// preset clears both conditions and leaves no event behind
	task automatic t_preset();
		sstl_host_inst.send(sstl_pkg::CMD_STAT_PRESET, 16'h0000);
		ask(sstl_pkg::CMD_OPER_COND_QRY, 16'h0000);
		settle();
		ask(sstl_pkg::CMD_OPER_EVEN_QRY, 16'h0000);
		ask(sstl_pkg::CMD_QUES_EVEN_QRY, 16'h0000);
		sstl_host_inst.send(sstl_pkg::CMD_STAT_PRESET, 16'h0000);
		ask(sstl_pkg::CMD_QUES_COND_QRY, 16'h0000);
		ask(sstl_pkg::CMD_QUES_COND_QRY, 16'h3003);
	endtask

	// main sequence
	initial begin
		repeat (5) @(negedge mclk_i);
		rst_i = 1'b0;
		@(negedge mclk_i);
		chk(upper_voltage_ceiling_o, sstl_pkg::VOLT_MODEL_MAX);
		t_trig();
		t_oper();
		t_ques();
		t_preset();
		close_out();
	end
endmodule
